//--- bench/trapc_mem_model.sv
// bus partner: word memory with variable answer delay and a silent top region
module trapc_mem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // system bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack,
  // answer delay in cycles
  input  wire logic [2:0]  delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:4095];
  logic [2:0]  cnt;
  // addresses at 0xE000 and up never answer, so the unit must time out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'hA5A5;
      cnt       <= 3'h0;
    end else if (!mem_req) begin
      mem_ack   <= 1'b0;
      cnt       <= 3'h0;
      mem_rdata <= ~mem_rdata;
    end else if (!mem_ack && mem_addr < 16'hE000) begin
      if (cnt < delay) begin
        cnt <= cnt + 3'h1;
      end else begin
        mem_ack <= 1'b1;
        if (mem_we) begin
          mem[mem_addr[12:1]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[12:1]];
        end
      end
    end
  end
endmodule

//--- bench/trapc_unit_tb_top.sv
// self-checking bench for the trap and control unit
module trapc_unit_tb_top;
  import trapc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned INIT_N = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_valid, exec_ready;
  logic        mem_req, mem_we, mem_ack, bus_init, irq, irq_ack, pwr_fail, console_grant, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] r0_value, pc_out, psw_out, sp_out, mem_addr, mem_wdata, mem_rdata, irq_vec;
  logic [15:0] console_data, console_addr, op, npc, sp, ps;
  logic [15:0] tops [8];
  logic [15:0] tvec [8];
  logic [15:0] ccs [10];
  logic [2:0]  delay;
  trapc_exec_t exec;
  int          n_mismatch, total_checks, n;

  trapc_unit #(.INIT_CYCLES(INIT_N)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .exec, .exec_valid, .exec_ready, .r0_value, .pc_out,
    .psw_out, .sp_out, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .bus_init, .irq, .irq_vec, .irq_ack, .pwr_fail, .console_grant, .console_data,
    .console_addr);
  trapc_mem_model MEM (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .delay);

  always #5 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ready;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (exec_ready !== 1'b1 && n < 5000);
    if (exec_ready !== 1'b1) n_mismatch++;
  endtask

  // hand one instruction over; optionally wait until the unit is idle again
  task automatic run(input logic [15:0] o, input logic [15:0] pc, input logic ovf,
                     input logic una, input logic done);
    @(posedge pclk);
    exec_valid <= 1'b1;
    exec       <= '{o, pc, psw_out, sp_out, ovf, 1'b0, una};
    wait_ready();
    exec_valid <= 1'b0;
    if (done) begin
      wait_ready();
    end
  endtask

  function automatic logic [3:0] cc_exp(input logic [3:0] f, input logic [15:0] o);
    return o[4] ? (f | o[3:0]) : (f & ~o[3:0]);
  endfunction

  initial begin
    #900_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, exec_valid, irq, pwr_fail} = '0;
    {paddr, pwdata, exec, r0_value, irq_vec, delay} = '0;
    ccs  = '{16'h00A1, 16'h00A2, 16'h00A4, 16'h00A8, 16'h00B1, 16'h00B2, 16'h00B4, 16'h00B8,
             16'h00A0, 16'h00B0};
    tops = '{16'h8800, 16'h8900, OP_IOT, OP_BPT, 16'h0A00, 16'h0A00, 16'h0041, 16'h0801};
    tvec = '{VEC_EMT, VEC_UTRAP, VEC_IOT, VEC_TRACE, VEC_BUS, VEC_RSVD, VEC_BUS, VEC_BUS};
    for (int v = 4; v < 32; v += 4) begin
      MEM.mem[v / 2]     = 16'h2000 + 16'(v);
      MEM.mem[v / 2 + 1] = 16'(v / 4);
    end
    void'($urandom(58675));
    repeat (16) @(posedge pclk);
    presetn  <= 1'b1;
    r0_value <= 16'($urandom);
    check(sp_out, SP_RST);
    for (int i = 0; i < 40; i++) begin
      op = (i < 10) ? ccs[i] : (CC_BASE | 16'($urandom % 32));
      ps = {psw_out[15:4], cc_exp(psw_out[3:0], op)};
      run(op, 16'h0400, 1'b0, 1'b0, 1'b1);
      check(psw_out, ps);
    end
    $display("condition code test done");
    for (int i = 0; i < 8; i++) begin
      delay <= 3'($urandom);
      op  = (i < 2) ? (tops[i] | 16'($urandom % 256)) : tops[i];
      sp  = sp_out;
      ps  = psw_out;
      npc = 16'h0400 + 16'($urandom % 1024) * 16'h2;
      run(op, npc, i == 4, i == 5, 1'b1);
      check(sp_out, sp - 16'h4);
      check(MEM.mem[(sp - 16'h2) >> 1], ps);
      check(MEM.mem[(sp - 16'h4) >> 1], npc);
      check(pc_out, 16'h2000 + tvec[i]);
      check(psw_out, tvec[i] >> 2);
      run(OP_RTI, 16'h0, 1'b0, 1'b0, 1'b1);
      check(pc_out, npc);
      check(psw_out, ps);
      check(sp_out, sp);
    end
    $display("trap test done");
    sp  = sp_out;
    npc = 16'h0802;
    run(OP_WAIT, npc, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    check(mem_req, 1'b0);
    check(exec_ready, 1'b0);
    irq     <= 1'b1;
    irq_vec <= VEC_IOT;
    do @(posedge pclk); while (irq_ack !== 1'b1);
    irq <= 1'b0;
    @(posedge pclk);
    check(irq_ack, 1'b0);
    wait_ready();
    check(MEM.mem[sp_out >> 1], npc);
    check(sp_out, sp - 16'h4);
    check(pc_out, 16'h2000 + VEC_IOT);
    run(OP_RTI, 16'h0, 1'b0, 1'b0, 1'b1);
    check(pc_out, npc);
    MEM.mem[VEC_PWR / 2 + 1] = 16'h0010;
    pwr_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    wait_ready();
    check(psw_out, 16'h0010);
    npc = 16'h0904;
    run(OP_WAIT, npc, 1'b0, 1'b0, 1'b1);
    check(pc_out, 16'h2000 + VEC_TRACE);
    check(MEM.mem[sp_out >> 1], npc);
    run(OP_RTI, 16'h0, 1'b0, 1'b0, 1'b1);
    run(16'h00B1, 16'h0A00, 1'b0, 1'b0, 1'b1);
    check(pc_out, 16'h2000 + VEC_TRACE);
    check(MEM.mem[(sp_out + 16'h2) >> 1], 16'h0011);
    $display("wait and trace test done");
    ps = psw_out;
    run(OP_RESET, 16'h0500, 1'b0, 1'b0, 1'b0);
    n = 0;
    repeat (INIT_N + 20) begin
      @(posedge pclk);
      if (bus_init === 1'b1) n++;
    end
    check(n, INIT_N);
    check(psw_out, ps);
    $display("bus reset test done");
    npc = 16'h0602;
    run(OP_HALT, npc, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    check(console_grant, 1'b1);
    check(mem_req, 1'b0);
    check(console_data, r0_value);
    check(console_addr, npc - 16'h2);
    check(pc_out, npc);
    check(bus_init, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[3:0], ST_HALT);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    apb(1'b1, ADDR_SP, 32'hF000);
    apb(1'b1, ADDR_CTRL, 32'h1);
    run(16'h8800, 16'h0700, 1'b0, 1'b0, 1'b0);
    repeat (1200) @(posedge pclk);
    check(console_grant, 1'b1);
    check(console_addr, 16'h06FE);
    $display("halt test done");
    end_sim();
  end
endmodule

//--- design/trapc_pkg.sv
// package: constants, states and carriers of the trap and control unit
package trapc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned BUSTMO_US    = 10;
  localparam int unsigned BUSTMO_CYC   = BUSTMO_US * CLK_MHZ;
  localparam int unsigned INIT_TIME_MS = 20;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [15:0] OP_HALT     = 16'h0000;
  localparam logic [15:0] OP_WAIT     = 16'h0001;
  localparam logic [15:0] OP_RTI      = 16'h0002;
  localparam logic [15:0] OP_BPT      = 16'h0003;
  localparam logic [15:0] OP_IOT      = 16'h0004;
  localparam logic [15:0] OP_RESET    = 16'h0005;
  localparam logic [15:0] CC_MASK     = 16'hFFE0;
  localparam logic [15:0] CC_BASE     = 16'h00A0;
  localparam logic [15:0] CC_NOP_CLR  = 16'h00A0;
  localparam logic [15:0] CC_NOP_SET  = 16'h00B0;
  localparam logic [7:0]  EMT_HI      = 8'h88;
  localparam logic [7:0]  UTRAP_HI    = 8'h89;
  localparam logic [9:0]  JMP_HI      = 10'h001;
  localparam logic [6:0]  JSR_HI      = 7'h04;
  localparam logic [2:0]  MODE_REG    = 3'h0;
  localparam int unsigned CC_SET_BIT  = 4;
  localparam int unsigned PSW_T_BIT   = 4;

  // ****************************************
  // trap vectors and stack limit
  // ****************************************
  localparam logic [15:0] VEC_BUS     = 16'h0004;
  localparam logic [15:0] VEC_RSVD    = 16'h0008;
  localparam logic [15:0] VEC_TRACE   = 16'h000C;
  localparam logic [15:0] VEC_IOT     = 16'h0010;
  localparam logic [15:0] VEC_PWR     = 16'h0014;
  localparam logic [15:0] VEC_EMT     = 16'h0018;
  localparam logic [15:0] VEC_UTRAP   = 16'h001C;
  localparam logic [15:0] STK_LIMIT   = 16'h0100;
  localparam logic [15:0] WORD_STEP   = 16'h0002;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0]  ADDR_STATUS = 8'h00;
  localparam logic [7:0]  ADDR_CTRL   = 8'h04;
  localparam logic [7:0]  ADDR_PSW    = 8'h08;
  localparam logic [7:0]  ADDR_PC     = 8'h0C;
  localparam logic [7:0]  ADDR_SP     = 8'h10;
  localparam logic [7:0]  ADDR_CAUSE  = 8'h14;
  localparam int unsigned CTRL_CONT   = 0;
  localparam logic [15:0] PSW_RST     = 16'h0000;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [15:0] SP_RST      = 16'h1000;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_INIT    = 4'h1,
    ST_WAIT    = 4'h2,
    ST_HALT    = 4'h3,
    ST_PUSH_PS = 4'h4,
    ST_PUSH_PC = 4'h5,
    ST_VEC_PC  = 4'h6,
    ST_VEC_PS  = 4'h7,
    ST_POP_PC  = 4'h8,
    ST_POP_PS  = 4'h9
  } trapc_state_t;

  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] next_pc;
    logic [15:0] psw_res;
    logic [15:0] sp_res;
    logic        stk_ovf;
    logic        bus_err;
    logic        unassigned;
  } trapc_exec_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } trapc_mreq_t;

endpackage

//--- design/trapc_timer.sv
// cycle timer: flags every cycle of a run from the LIMIT-th cycle on, until run drops
module trapc_timer
  import trapc_pkg::*;
#(
  parameter int unsigned LIMIT = 1000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  output logic      expired
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = '0;
    if (run) begin
      cnt_nxt = (cnt_r == LAST) ? cnt_r : cnt_r + 1'b1;
    end
    expired = run && (cnt_r == LAST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

//--- design/trapc_unit.sv
// trap and control unit: condition codes, control ops, traps, apb console
// Functional notes
// - selected condition flags set or cleared by bit4
// - fixed codes clear or set single flags
// - codes selecting no flag change nothing
// - ORed operators change all selected flags together
// - bus reset pulses init, flags kept
// - wait stops fetches until an interrupt
// - interrupt ending wait stacks following address
// - halt stops, ends transfer, grants console
// - halted: keep pc, continue resumes, no init
// - trap pushes status then pc, loads vector
// - emulator trap range uses vector word 30
// - user trap range uses vector 34
// - io executive vector 20, breakpoint vector 14
// - return pops pc then status word
// - unassigned vector 10, register jumps vector 04
// - stack below limit: finish, then trap
// - odd address or bus timeout traps
// - trace bit traps after next instruction
// - trace flag latched at fetch
// - traced overflow: trace first, then overflow
// - no interrupt until first handler instruction done
// - traced wait traps immediately
// - bus error while stacking halts
//
// Chosen here: register access over APB and the register addresses.
module trapc_unit
  import trapc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_TIME_MS * 1000 * CLK_MHZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // datapath hand-off
  input  wire trapc_exec_t exec,
  input  wire logic        exec_valid,
  output logic             exec_ready,
  input  wire logic [15:0] r0_value,
  output logic [15:0]      pc_out,
  output logic [15:0]      psw_out,
  output logic [15:0]      sp_out,
  // system bus
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             bus_init,
  input  wire logic        irq,
  input  wire logic [15:0] irq_vec,
  output logic             irq_ack,
  input  wire logic        pwr_fail,
  // console
  output logic             console_grant,
  output logic [15:0]      console_data,
  output logic [15:0]      console_addr
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic        ack_s1, ack_s;
  logic        irq_s1, irq_s;
  logic        pf_s1, pf_s, pf_d;
  logic [15:0] ivec_s1, ivec_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1  <= 1'b0;
      ack_s   <= 1'b0;
      irq_s1  <= 1'b0;
      irq_s   <= 1'b0;
      pf_s1   <= 1'b0;
      pf_s    <= 1'b0;
      pf_d    <= 1'b0;
      ivec_s1 <= 16'h0000;
      ivec_s  <= 16'h0000;
    end else begin
      ack_s1  <= mem_ack;
      ack_s   <= ack_s1;
      irq_s1  <= irq;
      irq_s   <= irq_s1;
      pf_s1   <= pwr_fail;
      pf_s    <= pf_s1;
      pf_d    <= pf_s;
      ivec_s1 <= irq_vec;
      ivec_s  <= ivec_s1;
    end
  end

  // ****************************************
  // state
  // ****************************************
  trapc_state_t st_r, st_nxt;
  trapc_mreq_t  mreq_r, mreq_nxt;
  logic [15:0]  psw_r, psw_nxt, pc_r, pc_nxt, sp_r, sp_nxt;
  logic [15:0]  vec_r, vec_nxt, rdat_r, rdat_nxt, caddr_r, caddr_nxt;
  logic [15:0]  cdata_r, cdata_nxt;
  logic         tflag_r, tflag_nxt, trc_r, trc_nxt, ovf_r, ovf_nxt;
  logic         pf_r, pf_nxt, kovf_r, kovf_nxt, inh_r, inh_nxt;
  logic         busy_r, busy_nxt, ack_r, ack_nxt, init_r, init_nxt;
  logic         cont_r, cont_nxt;
  logic [31:0]  prd_r, prd_nxt;
  logic         tmo, init_done, accept, is_acc, acc_we, acc_err, done;
  logic         apb_wr, mapped, irq_ok;
  logic [15:0]  acc_addr, acc_wdata, op, wval;
  logic [3:0]   ccsel;

  trapc_timer #(.LIMIT(BUSTMO_CYC)) u_bus_tmo (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (mreq_r.req),
    .expired (tmo)
  );

  trapc_timer #(.LIMIT(INIT_CYCLES)) u_init_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (st_r == ST_INIT),
    .expired (init_done)
  );

  assign op     = exec.opcode;
  assign ccsel  = op[3:0];
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (paddr == ADDR_STATUS) || (paddr == ADDR_CTRL) || (paddr == ADDR_PSW) ||
                  (paddr == ADDR_PC) || (paddr == ADDR_SP) || (paddr == ADDR_CAUSE);
  assign wval   = pwdata[15:0];
  assign irq_ok = irq_s && !inh_r;
  assign exec_ready = (st_r == ST_IDLE) && !trc_r && !ovf_r && !pf_r && !irq_ok;
  assign accept = exec_valid && exec_ready;

  always_comb begin
    st_nxt = st_r;      psw_nxt = psw_r;     pc_nxt = pc_r;       sp_nxt = sp_r;
    vec_nxt = vec_r;    rdat_nxt = rdat_r;   caddr_nxt = caddr_r; mreq_nxt = mreq_r;
    tflag_nxt = tflag_r; trc_nxt = trc_r;    ovf_nxt = ovf_r;     kovf_nxt = kovf_r;
    pf_nxt = pf_r || (pf_s && !pf_d);
    inh_nxt = inh_r;    busy_nxt = busy_r;   ack_nxt = 1'b0;      cdata_nxt = cdata_r;
    is_acc = 1'b1;      acc_we = 1'b0;       acc_addr = sp_r;     acc_wdata = psw_r;
    acc_err = 1'b0;     done = 1'b0;
    unique case (st_r)
      ST_PUSH_PS: begin
        acc_we   = 1'b1;
        acc_addr = sp_r - WORD_STEP;
      end
      ST_PUSH_PC: begin
        acc_we    = 1'b1;
        acc_addr  = sp_r - WORD_STEP;
        acc_wdata = pc_r;
      end
      ST_VEC_PC: acc_addr = vec_r;
      ST_VEC_PS: acc_addr = vec_r + WORD_STEP;
      ST_POP_PC, ST_POP_PS: acc_addr = sp_r;
      default: is_acc = 1'b0;
    endcase
    // interlocked access: raise req, wait ack, drop req, wait ack low
    if (is_acc) begin
      if (!busy_r) begin
        if (acc_addr[0]) begin
          acc_err = 1'b1;
        end else begin
          busy_nxt = 1'b1;
          mreq_nxt = '{req: 1'b1, we: acc_we, addr: acc_addr, wdata: acc_wdata};
          if (acc_we) begin
            sp_nxt = acc_addr;
            if (acc_addr < STK_LIMIT && !kovf_r) begin
              ovf_nxt = 1'b1;
            end
          end
        end
      end else if (mreq_r.req) begin
        if (ack_s) begin
          mreq_nxt.req = 1'b0;
          rdat_nxt     = mem_rdata;
        end else if (tmo) begin
          acc_err = 1'b1;
        end
      end else if (!ack_s) begin
        busy_nxt = 1'b0;
        done     = 1'b1;
      end
    end
    if (acc_err) begin
      busy_nxt     = 1'b0;
      mreq_nxt.req = 1'b0;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (trc_r) begin
          trc_nxt  = 1'b0;
          kovf_nxt = 1'b0;
          vec_nxt  = VEC_TRACE;
          inh_nxt  = 1'b1;
          st_nxt   = ST_PUSH_PS;
        end else if (ovf_r) begin
          ovf_nxt  = 1'b0;
          kovf_nxt = 1'b1;
          vec_nxt  = VEC_BUS;
          inh_nxt  = 1'b1;
          st_nxt   = ST_PUSH_PS;
        end else if (pf_r) begin
          // a new power edge in the same cycle keeps the request pending
          pf_nxt   = pf_s && !pf_d;
          kovf_nxt = 1'b0;
          vec_nxt  = VEC_PWR;
          inh_nxt  = 1'b1;
          st_nxt   = ST_PUSH_PS;
        end else if (irq_ok) begin
          ack_nxt  = 1'b1;
          kovf_nxt = 1'b0;
          vec_nxt  = ivec_s;
          inh_nxt  = 1'b1;
          st_nxt   = ST_PUSH_PS;
        end else if (accept) begin
          tflag_nxt = psw_r[PSW_T_BIT];
          pc_nxt    = exec.next_pc;
          kovf_nxt  = 1'b0;
          inh_nxt   = 1'b1;
          st_nxt    = ST_PUSH_PS;
          if (exec.bus_err) begin
            vec_nxt = VEC_BUS;
          end else if (op == OP_HALT) begin
            // stop and hand the bus over
            inh_nxt   = 1'b0;
            caddr_nxt = exec.next_pc - WORD_STEP;
            cdata_nxt = r0_value;
            st_nxt    = ST_HALT;
          end else if (op == OP_WAIT) begin
            if (psw_r[PSW_T_BIT]) begin
              vec_nxt = VEC_TRACE;
            end else begin
              inh_nxt = 1'b0;
              st_nxt  = ST_WAIT;
            end
          end else if (op == OP_RESET) begin
            inh_nxt = 1'b0;
            trc_nxt = psw_r[PSW_T_BIT];
            st_nxt  = ST_INIT;
          end else if (op == OP_RTI) begin
            inh_nxt = 1'b0;
            st_nxt  = ST_POP_PC;
          end else if (op == OP_BPT) begin
            vec_nxt = VEC_TRACE;
          end else if (op == OP_IOT) begin
            vec_nxt = VEC_IOT;
          end else if (op[15:8] == EMT_HI) begin
            vec_nxt = VEC_EMT;
          end else if (op[15:8] == UTRAP_HI) begin
            vec_nxt = VEC_UTRAP;
          // register mode jumps and unassigned codes
          end else if ((op[15:6] == JMP_HI || op[15:9] == JSR_HI) && op[5:3] == MODE_REG) begin
            vec_nxt = VEC_BUS;
          end else if (exec.unassigned) begin
            vec_nxt = VEC_RSVD;
          end else if ((op & CC_MASK) == CC_BASE) begin
            // masked set or clear of selected flags
            inh_nxt = 1'b0;
            st_nxt  = ST_IDLE;
            trc_nxt = psw_r[PSW_T_BIT];
            psw_nxt[3:0] = op[CC_SET_BIT] ? (psw_r[3:0] | ccsel) : (psw_r[3:0] & ~ccsel);
          end else begin
            inh_nxt = 1'b0;
            st_nxt  = ST_IDLE;
            psw_nxt = exec.psw_res;
            sp_nxt  = exec.sp_res;
            trc_nxt = psw_r[PSW_T_BIT];
            ovf_nxt = exec.stk_ovf;
          end
        end
      end
      ST_INIT: begin
        if (init_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // pc already holds the following address
        if (irq_s) begin
          ack_nxt  = 1'b1;
          kovf_nxt = 1'b0;
          vec_nxt  = ivec_s;
          inh_nxt  = 1'b1;
          st_nxt   = ST_PUSH_PS;
        end
      end
      ST_HALT: begin
        if (cont_r) begin
          st_nxt = ST_IDLE;
        end else if (apb_wr && paddr == ADDR_PSW) begin
          psw_nxt = wval;
        end else if (apb_wr && paddr == ADDR_PC) begin
          pc_nxt = wval;
        end else if (apb_wr && paddr == ADDR_SP) begin
          sp_nxt = wval;
        end
      end
      // status then pc pushed, vector loaded
      ST_PUSH_PS: if (done) st_nxt = ST_PUSH_PC;
      ST_PUSH_PC: if (done) st_nxt = ST_VEC_PC;
      ST_VEC_PC: begin
        if (done) begin
          pc_nxt = rdat_r;
          st_nxt = ST_VEC_PS;
        end
      end
      ST_VEC_PS: begin
        if (done) begin
          psw_nxt = rdat_r;
          st_nxt  = ST_IDLE;
        end
      end
      ST_POP_PC: begin
        if (done) begin
          pc_nxt = rdat_r;
          sp_nxt = sp_r + WORD_STEP;
          st_nxt = ST_POP_PS;
        end
      end
      ST_POP_PS: begin
        if (done) begin
          psw_nxt = rdat_r;
          sp_nxt  = sp_r + WORD_STEP;
          st_nxt  = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (acc_err) begin
      if (st_r == ST_POP_PC || st_r == ST_POP_PS) begin
        vec_nxt  = VEC_BUS;
        kovf_nxt = 1'b0;
        inh_nxt  = 1'b1;
        st_nxt   = ST_PUSH_PS;
      end else begin
        caddr_nxt = pc_r - WORD_STEP;
        cdata_nxt = r0_value;
        st_nxt    = ST_HALT;
      end
    end
    init_nxt = (st_nxt == ST_INIT);
  end

  // apb: read data is latched in the setup cycle, zero wait states
  always_comb begin
    cont_nxt = apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_CONT];
    prd_nxt  = prd_r;
    if (psel && !penable) begin
      prd_nxt = 32'h0000_0000;
      unique case (paddr)
        ADDR_STATUS: prd_nxt[10:0] = {tflag_r, trc_r, ovf_r, pf_r, inh_r, busy_r,
                                      init_r, st_r};
        ADDR_PSW:    prd_nxt[15:0] = psw_r;
        ADDR_PC:     prd_nxt[15:0] = pc_r;
        ADDR_SP:     prd_nxt[15:0] = sp_r;
        ADDR_CAUSE:  prd_nxt[15:0] = vec_r;
        default:     prd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;    psw_r <= PSW_RST;    pc_r <= PC_RST;       sp_r <= SP_RST;
      vec_r <= 16'h0000;  rdat_r <= 16'h0000;  caddr_r <= 16'h0000;  cdata_r <= 16'h0000;
      mreq_r <= '0;       tflag_r <= 1'b0;     trc_r <= 1'b0;        ovf_r <= 1'b0;
      pf_r <= 1'b0;       kovf_r <= 1'b0;      inh_r <= 1'b0;        busy_r <= 1'b0;
      ack_r <= 1'b0;      init_r <= 1'b0;      cont_r <= 1'b0;       prd_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;     psw_r <= psw_nxt;    pc_r <= pc_nxt;       sp_r <= sp_nxt;
      vec_r <= vec_nxt;   rdat_r <= rdat_nxt;  caddr_r <= caddr_nxt; cdata_r <= cdata_nxt;
      mreq_r <= mreq_nxt; tflag_r <= tflag_nxt; trc_r <= trc_nxt;    ovf_r <= ovf_nxt;
      pf_r <= pf_nxt;     kovf_r <= kovf_nxt;  inh_r <= inh_nxt;     busy_r <= busy_nxt;
      ack_r <= ack_nxt;   init_r <= init_nxt;  cont_r <= cont_nxt;   prd_r <= prd_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata        = prd_r;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !mapped;
  assign pc_out        = pc_r;
  assign psw_out       = psw_r;
  assign sp_out        = sp_r;
  assign mem_req       = mreq_r.req;
  assign mem_we        = mreq_r.we;
  assign mem_addr      = mreq_r.addr;
  assign mem_wdata     = mreq_r.wdata;
  assign bus_init      = init_r;
  assign irq_ack       = ack_r;
  assign console_grant = (st_r == ST_HALT);
  assign console_data  = cdata_r;
  assign console_addr  = caddr_r;

  // ****************************************
  // assertions
  // ****************************************
  cc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && st_nxt == ST_IDLE && (op & CC_MASK) == CC_BASE && op[CC_SET_BIT]
    |=> (psw_r[3:0] & $past(ccsel)) == $past(ccsel))
    else $error("selected flags not set");
  cc_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !exec.bus_err && (op == CC_NOP_CLR || op == CC_NOP_SET)
    |=> $stable(psw_r[3:0]))
    else $error("no-operation code changed flags");
  wait_nobus_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_WAIT |-> !mem_req && !exec_ready)
    else $error("bus used during wait");
  halt_console_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_HALT |-> !mem_req && console_grant && !bus_init)
    else $error("halt did not release bus");
  push_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mem_req) && mem_we |-> sp_r == mem_addr && $past(sp_r) == mem_addr + WORD_STEP)
    else $error("push not predecremented");
  emt_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !exec.bus_err && op[15:8] == EMT_HI
    |=> st_r == ST_PUSH_PS && vec_r == VEC_EMT)
    else $error("emulator trap vector wrong");
  irq_inhib_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_IDLE && inh_r |=> !irq_ack)
    else $error("interrupt taken while inhibited");
  wait_trace_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !exec.bus_err && op == OP_WAIT && psw_r[PSW_T_BIT]
    |=> st_r == ST_PUSH_PS && vec_r == VEC_TRACE)
    else $error("traced wait did not trap");
  stack_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_err && (st_r == ST_PUSH_PS || st_r == ST_PUSH_PC) |=> st_r == ST_HALT)
    else $error("stacking bus error did not halt");

endmodule
